// ===== design/bje_unit.sv
// branch and jump execution unit: decode, target, checks, far dispatch
// Functional notes
// RQ1: opcode 77 is one opcode whichever of its two names is used.
// RQ2: conditional jumps stay in the current code segment, never load a selector.
// RQ3: count-zero forms ignore flags, branch when the count register is zero.
// RQ4: every taken branch becomes a fetch of one or two cache lines; a taken task switch raises no FETCH_REQ here.
// RQ5: protected mode target beyond code limit raises fault with error zero.
// RQ6: real/v86 target beyond limit or above FFFF raises fault.
// RQ7: EB carries rel8, E9 carries rel16 or rel32 by operand size.
// RQ8: FF with reg field 4 is near indirect jump.
// RQ9: EA is far direct, FF with reg field 5 far indirect.
// RQ10: jumps save no return address or return state.
// RQ11: relative target is sign-extended displacement plus following instruction pointer.
// RQ12: absolute near target loads unchanged, sized by operand size.
// RQ13: operand size 16 clears upper two bytes of new pointer; a call gate jump sizes its offset by gate32 instead.
// RQ14: near jumps leave the code segment register alone.
// RQ15: far jump loads selector and offset of 4 or 6 byte pointer.
// RQ16: protected far jump reads descriptor and dispatches by its type.
// RQ17: protected far jump to code segment checks access rights first.
// RQ18: jumps never change privilege; a crossing jump is refused.
// RQ19: call gate jump uses gate selector and offset, no stack switch.
// RQ20: task jump ignores offset, via task gate or task state segment.
// RQ21: task switches by jump only in protected mode.
// RQ22: false condition continues at the following instruction.
// RQ23: greater/less signed on sign, overflow, zero; above/below on carry, zero.
// RQ24: count-zero form picks wide or narrow count by address size.
// RQ25: flags untouched except when a jump switches tasks.
`timescale 1ns/10ps
`default_nettype none

module bje_unit #(
	parameter int LINE_BYTES = bje_pkg::LINE_BYTES_DEF,
	parameter int FETCH_BYTES = bje_pkg::FETCH_BYTES_DEF
) (
	input wire logic SYS_CLK, // core clock
	input wire logic SRST, // synchronous reset, high
	input wire logic INSN_VALID, // instruction offered
	input wire bje_pkg::bje_insn_t INSN, // decoded instruction fields
	input wire bje_pkg::bje_flags_t FLAGS, // status flags
	input wire logic [31:0] COUNT, // wide count register
	input wire bje_pkg::bje_mode_t MODE, // mode, privilege, code limit
	input wire logic DESC_VALID, // descriptor answer present
	input wire bje_pkg::bje_desc_t DESC, // descriptor contents
	output logic BUSY, // far dispatch in progress
	output logic DONE, // result pulse
	output logic TAKEN, // branch taken
	output logic [31:0] NEW_IP, // next instruction pointer
	output logic CS_LOAD, // code segment reload
	output logic [15:0] NEW_CS, // new code segment selector
	output logic FAULT, // fault raised
	output logic FAULT_NP, // not-present instead of protection
	output logic [15:0] FAULT_CODE, // error code
	output logic FETCH_REQ, // code fetch request pulse
	output logic [31:0] FETCH_ADDR, // fetch offset
	output logic [1:0] FETCH_LINES, // lines to fetch
	output logic DESC_REQ, // descriptor read pulse
	output logic [15:0] DESC_SEL, // selector to read
	output logic TASK_REQ, // task switch pulse
	output logic [15:0] TASK_SEL, // task state segment selector
	output logic FLAGS_MOD // flags will change
);

	initial
	begin
		if (LINE_BYTES < 2 * FETCH_BYTES || FETCH_BYTES < 1 || LINE_BYTES > 256
			|| (LINE_BYTES & (LINE_BYTES - 1)) != 0)
			$error("bje_unit: unsupported line or fetch size");
	end

	typedef enum {ST_IDLE, ST_DESC, ST_GATE_CS} bje_state_t;

	bje_state_t state_reg, state_next;
	bje_pkg::bje_insn_t held_reg;
	bje_pkg::bje_desc_t gate_reg;

	////////////////////////////////////////////////////////////////
	// decode

	logic is_two, is_jcc_s, is_jcc_n, is_cz, is_rel8, is_rel, is_near_ind;
	logic is_far_dir, is_far_ind, is_far, is_cond, cond_take;
	logic [3:0] cc;
	logic [31:0] rel_ext, near_tmp, near_ip, far_tmp;
	logic real_mode, prot;

	assign is_two = INSN.opcode == bje_pkg::OP_TWO_BYTE;
	assign is_jcc_s = INSN.opcode[7:4] == bje_pkg::OP_JCC_SHORT_HI; // RQ1
	assign is_jcc_n = is_two && INSN.opcode2[7:4] == bje_pkg::OP_JCC_NEAR_HI;
	assign is_cz = INSN.opcode == bje_pkg::OP_COUNT_ZERO;
	assign is_rel8 = INSN.opcode == bje_pkg::OP_JMP_REL8; // RQ7
	assign is_rel = INSN.opcode == bje_pkg::OP_JMP_REL; // RQ7
	assign is_near_ind = INSN.opcode == bje_pkg::OP_GROUP5
		&& INSN.modrm_reg == bje_pkg::REG_NEAR_IND; // RQ8
	assign is_far_dir = INSN.opcode == bje_pkg::OP_JMP_FAR; // RQ9
	assign is_far_ind = INSN.opcode == bje_pkg::OP_GROUP5
		&& INSN.modrm_reg == bje_pkg::REG_FAR_IND; // RQ9
	assign is_far = is_far_dir || is_far_ind;
	assign is_cond = is_jcc_s || is_jcc_n || is_cz;
	assign cc = is_two ? INSN.opcode2[3:0] : INSN.opcode[3:0];
	assign real_mode = !MODE.protected_en || MODE.v86_en;
	assign prot = !real_mode;

	bje_cond u_cond (
		.cc(cc),
		.count_form(is_cz),
		.addr32(INSN.addr32),
		.count(COUNT),
		.flags(FLAGS),
		.take(cond_take)
	);

	always_comb
	begin
		// short forms carry rel8; rel16 is sign-extended then masked below
		if (is_jcc_s || is_cz || is_rel8)
			rel_ext = {{24{INSN.imm[7]}}, INSN.imm[7:0]};
		else if (INSN.op32)
			rel_ext = INSN.imm;
		else
			rel_ext = {{16{INSN.imm[15]}}, INSN.imm[15:0]};
		if (is_near_ind)
			near_tmp = INSN.op32 ? INSN.operand : (INSN.operand & bje_pkg::IP16_MASK); // RQ12
		else
			near_tmp = INSN.next_ip + rel_ext; // RQ11
		near_ip = INSN.op32 ? near_tmp : (near_tmp & bje_pkg::IP16_MASK); // RQ13
		// far pointer offset: imm (direct) or operand (indirect) holds offset, sel the selector (4 or 6 bytes)
		far_tmp = is_far_dir ? INSN.imm : INSN.operand; // RQ15
	end

	logic near_bad, far_real_bad;
	logic [31:0] far_ip;

	assign near_bad = near_tmp > MODE.cs_limit
		|| (real_mode && near_tmp > bje_pkg::REAL_SPACE_TOP); // RQ5 RQ6
	assign far_real_bad = far_tmp > MODE.cs_limit || far_tmp > bje_pkg::REAL_SPACE_TOP; // RQ6
	assign far_ip = INSN.op32 ? far_tmp : (far_tmp & bje_pkg::IP16_MASK); // RQ13

	////////////////////////////////////////////////////////////////
	// descriptor checks on the held far jump

	logic [1:0] cpl, rpl;
	logic [31:0] hold_raw, hold_off, gate_off;
	logic code_bad, gate_bad, tss_bad, task_bad, gate_code_bad;
	logic [15:0] sel_code, gate_code;

	assign cpl = MODE.cpl;
	assign rpl = held_reg.sel[1:0];
	// only a code segment target uses the pointer offset; gates and tasks ignore it
	assign hold_raw = held_reg.opcode == bje_pkg::OP_JMP_FAR
		? held_reg.imm : held_reg.operand; // RQ15
	assign hold_off = held_reg.op32 ? hold_raw : (hold_raw & bje_pkg::IP16_MASK); // RQ13
	assign gate_off = gate_reg.gate32 ? gate_reg.gate_off
		: (gate_reg.gate_off & bje_pkg::IP16_MASK); // RQ19

	// privilege never moves: conforming needs DPL<=CPL, other code DPL==CPL
	assign code_bad = DESC.conforming ? (DESC.dpl > cpl)
		: (rpl > cpl || DESC.dpl != cpl); // RQ17 RQ18
	assign gate_bad = DESC.dpl < cpl || DESC.dpl < rpl; // RQ18
	assign tss_bad = gate_bad || DESC.tss_busy;
	// busy bit of a gated task lives in a descriptor not read here
	assign task_bad = DESC.kind == bje_pkg::DESC_TSS ? tss_bad : gate_bad; // RQ20
	// code reached through a gate: no selector privilege, same level rule
	assign gate_code_bad = DESC.kind != bje_pkg::DESC_CODE
		|| (DESC.conforming ? (DESC.dpl > cpl) : (DESC.dpl != cpl)); // RQ18
	assign sel_code = {held_reg.sel[15:2], 2'h0};
	assign gate_code = {gate_reg.gate_sel[15:2], 2'h0};

	////////////////////////////////////////////////////////////////
	// sequencing

	localparam logic [31:0] LINE_MASK = 32'(LINE_BYTES - 1);
	localparam logic [31:0] LINE_SIZE = 32'(LINE_BYTES);
	localparam logic [31:0] FETCH_SIZE = 32'(FETCH_BYTES);

	logic accept, fin, res_taken, res_cs_load, res_fault, res_np, res_task;
	logic desc_req_next;
	logic [31:0] res_ip;
	logic [15:0] res_cs, res_code, res_task_sel, desc_sel_next;

	assign accept = state_reg == ST_IDLE && INSN_VALID;

	function automatic logic [1:0] lines_for(input logic [31:0] t);
		logic [31:0] room;
		room = LINE_SIZE - (t & LINE_MASK);
		// a fetch that would run past the line end needs the next line too
		return (room < FETCH_SIZE) ? 2'h2 : 2'h1; // RQ4
	endfunction

	always_comb
	begin
		state_next = state_reg;
		fin = 1'b0;
		res_taken = 1'b0;
		res_ip = INSN.next_ip;
		res_cs_load = 1'b0;
		res_cs = bje_pkg::CS_RESET;
		res_fault = 1'b0;
		res_np = 1'b0;
		res_code = bje_pkg::ERR_ZERO;
		res_task = 1'b0;
		res_task_sel = 16'h0000;
		desc_req_next = 1'b0;
		desc_sel_next = DESC_SEL;
		case (state_reg)
		ST_IDLE:
			if (accept && is_far && prot)
			begin
				if (INSN.sel[15:2] == 14'h0000)
				begin
					fin = 1'b1;
					res_fault = 1'b1;
				end
				else
				begin
					state_next = ST_DESC; // RQ16
					desc_req_next = 1'b1;
					desc_sel_next = INSN.sel;
				end
			end
			else if (accept && is_far)
			begin
				fin = 1'b1;
				if (far_real_bad)
					res_fault = 1'b1; // RQ6
				else
				begin
					res_taken = 1'b1;
					res_ip = far_ip; // RQ15
					res_cs_load = 1'b1;
					res_cs = INSN.sel;
				end
			end
			else if (accept && (is_cond || is_rel8 || is_rel || is_near_ind))
			begin
				fin = 1'b1;
				if (is_cond && !cond_take)
					res_ip = INSN.next_ip; // RQ22
				else if (near_bad)
					res_fault = 1'b1; // RQ5 RQ6
				else
				begin
					// near and conditional forms never reload the selector
					res_taken = 1'b1;
					res_ip = near_ip; // RQ2 RQ14
				end
			end
			else if (accept)
				fin = 1'b1;
		ST_DESC:
			if (DESC_VALID)
			begin
				fin = 1'b1;
				state_next = ST_IDLE;
				case (DESC.kind)
				bje_pkg::DESC_CODE:
					if (code_bad)
					begin
						res_fault = 1'b1; // RQ17 RQ18
						res_code = sel_code;
					end
					else if (!DESC.present)
					begin
						res_fault = 1'b1;
						res_np = 1'b1;
						res_code = sel_code;
					end
					else if (hold_off > DESC.limit)
						res_fault = 1'b1; // RQ5
					else
					begin
						res_taken = 1'b1;
						res_ip = hold_off;
						res_cs_load = 1'b1;
						res_cs = {held_reg.sel[15:2], cpl}; // RQ18
					end
				bje_pkg::DESC_CALL_GATE:
					if (gate_bad)
					begin
						res_fault = 1'b1; // RQ18
						res_code = sel_code;
					end
					else if (!DESC.present)
					begin
						res_fault = 1'b1;
						res_np = 1'b1;
						res_code = sel_code;
					end
					else if (DESC.gate_sel[15:2] == 14'h0000)
						res_fault = 1'b1;
					else
					begin
						fin = 1'b0;
						state_next = ST_GATE_CS; // RQ19
						desc_req_next = 1'b1;
						desc_sel_next = DESC.gate_sel;
					end
				bje_pkg::DESC_TASK_GATE, bje_pkg::DESC_TSS:
					if (task_bad)
					begin
						res_fault = 1'b1;
						res_code = sel_code;
					end
					else if (!DESC.present)
					begin
						res_fault = 1'b1;
						res_np = 1'b1;
						res_code = sel_code;
					end
					else
					begin
						// only reachable with protection on
						res_taken = 1'b1; // RQ21
						res_task = 1'b1; // RQ20
						res_task_sel = DESC.kind == bje_pkg::DESC_TSS
							? held_reg.sel : DESC.gate_sel; // RQ20
					end
				default:
				begin
					res_fault = 1'b1;
					res_code = sel_code;
				end
				endcase
			end
		ST_GATE_CS:
			if (DESC_VALID)
			begin
				fin = 1'b1;
				state_next = ST_IDLE;
				if (gate_code_bad)
				begin
					res_fault = 1'b1; // RQ18
					res_code = gate_code;
				end
				else if (!DESC.present)
				begin
					res_fault = 1'b1;
					res_np = 1'b1;
					res_code = gate_code;
				end
				else if (gate_off > DESC.limit)
					res_fault = 1'b1; // RQ5
				else
				begin
					// no stack is touched on this path
					res_taken = 1'b1;
					res_ip = gate_off; // RQ19
					res_cs_load = 1'b1;
					res_cs = {gate_reg.gate_sel[15:2], cpl}; // RQ19
				end
			end
		default:
			state_next = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state and held operands

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			state_reg <= ST_IDLE;
			BUSY <= 1'b0;
			DESC_REQ <= 1'b0;
			DESC_SEL <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			BUSY <= state_next != ST_IDLE;
			DESC_REQ <= desc_req_next; // RQ16
			DESC_SEL <= desc_sel_next;
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (accept)
			held_reg <= INSN;
		if (state_reg == ST_DESC && DESC_VALID)
			gate_reg <= DESC;
	end

	////////////////////////////////////////////////////////////////
	// results

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			DONE <= 1'b0;
			TAKEN <= 1'b0;
			NEW_IP <= bje_pkg::IP_RESET;
			CS_LOAD <= 1'b0;
			NEW_CS <= bje_pkg::CS_RESET;
			FAULT <= 1'b0;
			FAULT_NP <= 1'b0;
			FAULT_CODE <= bje_pkg::ERR_ZERO;
			TASK_REQ <= 1'b0;
			TASK_SEL <= 16'h0000;
			FLAGS_MOD <= 1'b0;
		end
		else
		begin
			DONE <= fin;
			CS_LOAD <= fin && res_cs_load;
			TASK_REQ <= fin && res_task;
			FLAGS_MOD <= fin && res_task; // RQ25
			if (fin)
			begin
				// result fields stand until the next result; no return state kept
				TAKEN <= res_taken;
				NEW_IP <= res_ip; // RQ10
				NEW_CS <= res_cs;
				FAULT <= res_fault;
				FAULT_NP <= res_np;
				FAULT_CODE <= res_code; // RQ5
				TASK_SEL <= res_task_sel;
			end
		end
	end

	// task targets come from the new task state, fetched by the switch logic
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			FETCH_REQ <= 1'b0;
			FETCH_ADDR <= bje_pkg::IP_RESET;
			FETCH_LINES <= 2'h0;
		end
		else
		begin
			FETCH_REQ <= fin && res_taken && !res_task; // RQ4
			if (fin && res_taken && !res_task)
			begin
				FETCH_ADDR <= res_ip;
				FETCH_LINES <= lines_for(res_ip); // RQ4
			end
		end
	end
endmodule

`default_nettype wire

// ===== include/bje_pkg.sv
// shared types and constants of the branch/jump execution unit
package bje_pkg;

	localparam logic [7:0] OP_TWO_BYTE = 8'h0F;
	localparam logic [3:0] OP_JCC_SHORT_HI = 4'h7;
	localparam logic [3:0] OP_JCC_NEAR_HI = 4'h8;
	localparam logic [7:0] OP_COUNT_ZERO = 8'hE3;
	localparam logic [7:0] OP_JMP_REL8 = 8'hEB;
	localparam logic [7:0] OP_JMP_REL = 8'hE9;
	localparam logic [7:0] OP_JMP_FAR = 8'hEA;
	localparam logic [7:0] OP_GROUP5 = 8'hFF;
	localparam logic [2:0] REG_NEAR_IND = 3'h4;
	localparam logic [2:0] REG_FAR_IND = 3'h5;

	localparam logic [31:0] IP16_MASK = 32'h0000FFFF;
	localparam logic [31:0] REAL_SPACE_TOP = 32'h0000FFFF;
	localparam logic [15:0] ERR_ZERO = 16'h0000;
	localparam logic [31:0] IP_RESET = 32'h00000000;
	localparam logic [15:0] CS_RESET = 16'h0000;

	localparam logic [2:0] DESC_CODE = 3'h0;
	localparam logic [2:0] DESC_CALL_GATE = 3'h1;
	localparam logic [2:0] DESC_TASK_GATE = 3'h2;
	localparam logic [2:0] DESC_TSS = 3'h3;
	localparam logic [2:0] DESC_OTHER = 3'h4;

	localparam int LINE_BYTES_DEF = 32;
	localparam int FETCH_BYTES_DEF = 16;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] opcode2;
		logic [2:0] modrm_reg;
		logic [31:0] imm;
		logic [31:0] operand;
		logic [15:0] sel;
		logic op32;
		logic addr32;
		logic [31:0] next_ip;
	} bje_insn_t;

	typedef struct packed {
		logic carry_flag;
		logic parity_flag;
		logic zero_flag;
		logic sign_flag;
		logic overflow_flag;
	} bje_flags_t;

	typedef struct packed {
		logic protected_en;
		logic v86_en;
		logic [1:0] cpl;
		logic [31:0] cs_limit;
	} bje_mode_t;

	typedef struct packed {
		logic [2:0] kind;
		logic [1:0] dpl;
		logic present;
		logic conforming;
		logic tss_busy;
		logic [31:0] limit;
		logic [15:0] gate_sel;
		logic [31:0] gate_off;
		logic gate32;
	} bje_desc_t;

endpackage

// ===== design/bje_cond.sv
// condition evaluator for conditional and count-zero jumps
`timescale 1ns/10ps
`default_nettype none

module bje_cond (
	input wire logic [3:0] cc, // condition nibble of the opcode
	input wire logic count_form, // count-zero form selected
	input wire logic addr32, // address-size attribute 32
	input wire logic [31:0] count, // wide count register
	input wire bje_pkg::bje_flags_t flags, // status flags
	output logic take // condition true
);

	logic base;

	always_comb
	begin
		// 77 and 0F 87 share this path whichever name is used
		case (cc[3:1]) // RQ1
		3'h0: base = flags.overflow_flag;
		3'h1: base = flags.carry_flag; // RQ23
		3'h2: base = flags.zero_flag;
		3'h3: base = flags.carry_flag | flags.zero_flag; // RQ23
		3'h4: base = flags.sign_flag;
		3'h5: base = flags.parity_flag;
		3'h6: base = flags.sign_flag ^ flags.overflow_flag; // RQ23
		3'h7: base = flags.zero_flag | (flags.sign_flag ^ flags.overflow_flag); // RQ23
		default: base = 1'b0;
		endcase
		if (count_form)
			take = addr32 ? (count == 32'h00000000) : (count[15:0] == 16'h0000); // RQ3 RQ24
		else
			take = base ^ cc[0];
	end

endmodule

`default_nettype wire

// ===== sim/bje_unit_asserts.sv
// port assertions for the jump unit
`timescale 1ns/10ps
`default_nettype none
module bje_chk (
	input wire logic SYS_CLK, // clock
	input wire logic SRST, // reset
	input wire logic INSN_VALID, // offer
	input wire bje_pkg::bje_insn_t INSN, // fields
	input wire bje_pkg::bje_flags_t FLAGS, // flags
	input wire logic [31:0] COUNT, // count
	input wire bje_pkg::bje_mode_t MODE, // mode
	input wire logic DONE, // result
	input wire logic TAKEN, // taken
	input wire logic [31:0] NEW_IP, // pointer
	input wire logic CS_LOAD, // reload
	input wire logic FAULT, // fault
	input wire logic [15:0] FAULT_CODE, // code
	input wire logic FETCH_REQ, // fetch
	input wire logic [1:0] FETCH_LINES, // lines
	input wire logic TASK_REQ, // task
	input wire logic FLAGS_MOD // flags
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (SRST);
logic [7:0] op;
logic [31:0] tgt;
// 00 is no jump, so an idle cycle never fires
assign op = INSN_VALID ? INSN.opcode : 8'h00;
assign tgt = INSN.next_ip + INSN.imm;
jcc_seg_a: assert property (op[7:4] == 4'h7 |-> ##[0:4] DONE && !CS_LOAD && !FLAGS_MOD)
	else $error("conditional jump touched segment or flags");
above_take_a: assert property (op == 8'h77 && !FLAGS.carry_flag && !FLAGS.zero_flag
	|-> ##[0:4] DONE && TAKEN) else $error("above not taken");
count_zero_a: assert property (op == 8'hE3 && INSN.addr32 && COUNT == 32'h0
	|-> ##[0:4] DONE && TAKEN) else $error("zero count not taken");
narrow_ip_a: assert property (op == 8'hEB && !INSN.op32
	|-> ##[0:4] DONE && NEW_IP[31:16] == 16'h0000) else $error("upper pointer kept");
prot_limit_a: assert property (op == 8'hE9 && MODE.protected_en && !MODE.v86_en
	&& INSN.op32 && tgt > MODE.cs_limit |-> ##[0:4] DONE && FAULT
	&& FAULT_CODE == bje_pkg::ERR_ZERO) else $error("limit fault missing");
real_space_a: assert property (op == 8'hE9 && !MODE.protected_en && INSN.op32
	&& tgt > 32'h0000FFFF |-> ##[0:4] DONE && FAULT) else $error("space fault missing");
fetch_lines_a: assert property (FETCH_REQ |-> FETCH_LINES == 2'h1 || FETCH_LINES == 2'h2)
	else $error("fetch line count");
task_mode_a: assert property (TASK_REQ |-> MODE.protected_en && !MODE.v86_en)
	else $error("task switch outside protected mode");
endmodule
bind bje_unit bje_chk u_bje_chk (.*);
`default_nettype wire

// ===== sim/bje_desc_model.sv
// descriptor table model answering the unit's reads
`timescale 1ns/10ps
`default_nettype none
module bje_desc_model (
	input wire logic SYS_CLK, // clock
	input wire logic SRST, // reset
	input wire logic slow, // answer late
	input wire logic DESC_REQ, // read pulse
	input wire logic [15:0] DESC_SEL, // selector
	output logic DESC_VALID, // answer
	output bje_pkg::bje_desc_t DESC // contents
);
logic [2:0] wait_reg;
logic [15:0] sel_reg;
always_ff @(posedge SYS_CLK)
begin
	DESC_VALID <= 1'b0;
	// stale contents flip so they never pass for an answer
	DESC <= SRST ? '0 : ~DESC;
	if (SRST)
		wait_reg <= 3'h0;
	else if (DESC_REQ)
	begin
		sel_reg <= DESC_SEL;
		wait_reg <= slow ? 3'h5 : 3'h1;
	end
	else if (wait_reg != 3'h0)
	begin
		wait_reg <= wait_reg - 3'h1;
		if (wait_reg == 3'h1)
		begin
			DESC_VALID <= 1'b1;
			// selector bit 7 marks a descriptor that is not present
			DESC <= '{sel_reg[5:3], 2'h0, !sel_reg[7], 1'b0, 1'b0, 32'h0000FFFF,
				16'h0040, 32'h00000100, 1'b1};
		end
	end
end
endmodule
`default_nettype wire

// ===== sim/bje_unit_tb.sv
// self-checking bench for the jump unit
`timescale 1ns/10ps
`default_nettype none
module bje_unit_tb;
logic SYS_CLK, SRST, INSN_VALID, DESC_VALID, slow, BUSY, DONE, TAKEN, CS_LOAD, FAULT, FAULT_NP;
logic FETCH_REQ, DESC_REQ, TASK_REQ, FLAGS_MOD, r_tk, r_flt, s_cs, s_task, s_fm, s_bsy;
logic [31:0] COUNT, cnt, NEW_IP, FETCH_ADDR, r_ip;
logic [15:0] NEW_CS, FAULT_CODE, DESC_SEL, TASK_SEL, r_cs, r_code;
logic [1:0] FETCH_LINES;
bje_pkg::bje_insn_t INSN;
bje_pkg::bje_flags_t FLAGS, fl;
bje_pkg::bje_mode_t MODE, md;
bje_pkg::bje_desc_t DESC;
int failures = 0;
int num_checks = 0;
bje_unit u_bje_unit (.*);
bje_desc_model u_bje_desc_model (.*);
////////////////////////////////////////
task finish_test;
	if (failures == 0 && num_checks > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task chk(input logic [31:0] seen, input logic [31:0] exp);
	num_checks++;
	if (seen !== exp)
	begin
		failures++;
		$display("ERROR %0t seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic run(input logic [15:0] op, input logic [31:0] imm, input logic o32 = 1'b1,
	input logic a32 = 1'b1, input logic [2:0] rg = 3'h0, input logic [31:0] opnd = 32'h0,
	input logic [15:0] sel = 16'h0);
	int n;
	@(negedge SYS_CLK);
	FLAGS <= fl;
	MODE <= md;
	COUNT <= cnt;
	INSN <= '{op[15:8], op[7:0], rg, imm, opnd, sel, o32, a32, 32'h00000100};
	INSN_VALID <= 1'b1;
	{s_cs, s_task, s_fm, s_bsy} = 4'h0;
	for (n = 0; n < 40; n++)
	begin
		@(posedge SYS_CLK);
		#1;
		// pulses come with the result but BUSY drops as it comes, so keep them sticky
		s_cs |= CS_LOAD;
		s_task |= TASK_REQ;
		s_fm |= FLAGS_MOD;
		s_bsy |= BUSY;
		if (DONE === 1'b1)
			break;
		@(negedge SYS_CLK);
		INSN_VALID <= 1'b0;
	end
	{r_tk, r_ip, r_cs, r_flt, r_code} = {TAKEN, NEW_IP, NEW_CS, FAULT, FAULT_CODE};
	chk(DONE, 1'b1);
	@(negedge SYS_CLK);
	INSN_VALID <= 1'b0;
endtask
////////////////////////////////////////
task t_cond;
	md = {1'b1, 1'b0, 2'h0, 32'hFFFFFFFF};
	fl = 5'b00000;
	run(16'h7700, 32'h10);
	chk(r_tk, 1'b1);
	chk(r_ip, 32'h110);
	run(16'h0F87, 32'h10);
	chk(r_tk, 1'b1);
	chk(s_cs, 1'b0);
	fl = 5'b10000;
	run(16'h7700, 32'h10);
	chk(r_tk, 1'b0);
	chk(r_ip, 32'h100);
	fl = 5'b00010;
	run(16'h7F00, 32'h10);
	chk(r_tk, 1'b0);
	fl = 5'b00011;
	run(16'h7F00, 32'h10);
	chk(r_tk, 1'b1);
endtask
task t_count;
	fl = 5'b11111;
	cnt = 32'h00010000;
	run(16'hE300, 32'h10, 1'b1, 1'b0);
	chk(r_tk, 1'b1);
	run(16'hE300, 32'h10);
	chk(r_tk, 1'b0);
	cnt = 32'h0;
endtask
task t_near;
	run(16'hEB00, 32'hFFFFFFF0);
	chk(r_ip, 32'hF0);
	chk(FETCH_ADDR, 32'hF0);
	chk(FETCH_LINES, 2'h1);
	run(16'hE900, 32'hFF00, 1'b0);
	chk(r_ip, 32'h0);
	run(16'hFF00, 32'h0, 1'b1, 1'b1, 3'h4, 32'h12345678);
	chk(r_ip, 32'h12345678);
	chk(FETCH_LINES, 2'h2);
	chk(s_cs, 1'b0);
endtask
task t_fault;
	md = {1'b1, 1'b0, 2'h0, 32'h1000};
	run(16'hE900, 32'h2000);
	chk({r_flt, r_code}, 17'h10000);
	md = {1'b0, 1'b0, 2'h0, 32'hFFFFFFFF};
	run(16'hE900, 32'h12000);
	chk(r_flt, 1'b1);
	run(16'hEA00, 32'h5678, 1'b1, 1'b1, 3'h0, 32'h0, 16'h0018);
	chk({s_cs, r_cs, r_ip}, {1'b1, 16'h0018, 32'h5678});
	chk(s_task, 1'b0);
endtask
task t_gate;
	md = {1'b1, 1'b0, 2'h0, 32'hFFFFFFFF};
	slow = 1'b1;
	run(16'hEA00, 32'h9999, 1'b1, 1'b1, 3'h0, 32'h0, 16'h0008);
	chk({r_cs, r_ip}, {16'h0040, 32'h100});
	chk(s_bsy, 1'b1);
	chk(DESC_SEL, 16'h0040);
	slow = 1'b0;
	run(16'hEA00, 32'h9999, 1'b1, 1'b1, 3'h0, 32'h0, 16'h0018);
	chk(s_task, 1'b1);
	chk(s_fm, 1'b1);
	chk(TASK_SEL, 16'h0018);
	run(16'hEA00, 32'h9999, 1'b1, 1'b1, 3'h0, 32'h0, 16'h0080);
	chk({r_flt, FAULT_NP}, 2'h3);
	md = {1'b1, 1'b0, 2'h1, 32'hFFFFFFFF};
	run(16'hEA00, 32'h9999, 1'b1, 1'b1, 3'h0, 32'h0, 16'h0041);
	chk({r_flt, s_cs}, 2'h2);
endtask
////////////////////////////////////////
initial
begin
	SYS_CLK = 1'b0;
	forever #4 SYS_CLK = ~SYS_CLK;
end
initial
begin
	// ample for some twenty jumps of at most forty cycles
	#100000;
	failures++;
	finish_test;
end
initial
begin
	{SRST, INSN_VALID, slow} = 3'h4;
	{INSN, FLAGS, fl, COUNT, cnt, MODE, md} = '0;
	repeat (6) @(negedge SYS_CLK);
	SRST = 1'b0;
	t_cond;
	t_count;
	t_near;
	t_fault;
	t_gate;
	finish_test;
end
endmodule
`default_nettype wire
